// >>> logic/adcs_defs.vh
/*
 * Constants for the converter control block: register offsets, field
 * positions, reset values, saturation codes and timing counts.
 * Assumes a byte-wide register port and a 125 MHz core clock.
 */
`ifndef ADCS_DEFS_VH
`define ADCS_DEFS_VH

// Register offsets on the byte register port.
`define ADCS_OFF_CSR 8'h70
`define ADCS_OFF_RES_HIGH 8'h71
`define ADCS_OFF_RES_LOW 8'h72
`define ADCS_OFF_IRQ_STATUS 8'h73
`define ADCS_OFF_IRQ_MASK 8'h74

// Control/status field positions.
`define ADCS_CSR_DONE 7
`define ADCS_CSR_SPEED 6
`define ADCS_CSR_ON 5
`define ADCS_CSR_RSVD 4
`define ADCS_CSR_CH_HI 3
`define ADCS_CSR_CH_LO 0

// Interrupt status and mask field positions.
`define ADCS_IRQ_DONE 0
`define ADCS_IRQ_SAT 1

// Reset values.
`define ADCS_RST_BYTE 8'h00
`define ADCS_RST_RESULT 10'h000

// Result codes and width.
`define ADCS_RES_BITS 10
`define ADCS_RES_FULL 10'h3FF
`define ADCS_RES_ZERO 10'h000
`define ADCS_RES_MSB 10'h200

// Timing: core clock period and converter settle time after halt.
`define ADCS_CLK_NS 8
`define ADCS_STAB_NS 1000
`define ADCS_STAB_CYC ((`ADCS_STAB_NS + `ADCS_CLK_NS - 1) / `ADCS_CLK_NS)

// Converter clock ticks spent sampling before the first trial.
`define ADCS_SAMPLE_TICKS 3

`endif

// >>> logic/adcs_control.v
/*
 * Control logic of a 10-bit successive approximation converter: byte
 * register port, channel select, continuous conversion, done flag,
 * result packing, saturation, halt handling and one interrupt line.
 * Assumes the analog core supplies a comparator output and two range
 * flags, all asynchronous to core_clk, and that halt_mode comes from
 * the clock controller on core_clk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "adcs_defs.vh"

// Operation
// - Above upper reference gives full-scale code.
// - Below lower reference gives zero code.
// - Converter on starts continuous back-to-back conversions.
// - Each completion loads result, sets done flag.
// - High byte read or control write clears done.
// - Results overwritten directly, no latched copy.
// - Channel change aborts, clears done, restarts.
// - Speed bit picks clock divide four/two.
// - Converter off disables and halts conversion.
// - Channel field is binary input index.
// - High byte bits 9:2, low byte 1:0.
// - Control register writable except done flag.
// - Reset clears control and both results.
// - Wait mode leaves the converter running.
// - Halt disables converter; settle after wakeup.
module adcs_control #(
  parameter SAMPLE_TICKS = `ADCS_SAMPLE_TICKS,
  parameter STAB_CYC = `ADCS_STAB_CYC
) (
  input wire core_clk, // Core clock, 125 MHz.
  input wire reset_n, // Asynchronous system reset, active low.
  input wire [7:0] reg_addr, // Register address.
  input wire [7:0] reg_wdata, // Register write data.
  input wire reg_wr, // Write strobe.
  input wire reg_rd, // Read strobe.
  output reg [7:0] reg_rdata, // Read data, one cycle after the strobe.
  input wire halt_mode, // Device is in halt mode.
  input wire comp_high, // Comparator: input at or above trial code.
  input wire above_upper, // Input above the upper reference.
  input wire below_lower, // Input below the lower reference.
  output wire conv_power, // Powers the analog converter core.
  output wire [3:0] mux_channel, // Analog multiplexer select.
  output reg sample_hold, // High while the core samples the input.
  output reg [9:0] trial_code, // Trial code for the comparator DAC.
  output wire irq // Level interrupt request.
);

  localparam ST_IDLE = 2'd0;
  localparam ST_SAMP = 2'd1;
  localparam ST_SET = 2'd2;
  localparam ST_CMP = 2'd3;

  // Address decode shared by every register strobe.
  function sel;
    input [7:0] addr;
    input [7:0] off;
    begin
      sel = (addr == off);
    end
  endfunction

  reg rst_s1;
  reg rst_n_int;
  reg comp_s1;
  reg comp_s2;
  reg over_s1;
  reg over_s2;
  reg under_s1;
  reg under_s2;
  reg conv_on;
  reg speed;
  reg [3:0] channel_field;
  reg conv_done_flag;
  reg [9:0] result;
  reg [1:0] irq_status;
  reg [1:0] irq_mask;
  reg [1:0] state;
  reg [1:0] div_cnt;
  reg [3:0] bit_idx;
  reg [7:0] samp_cnt;
  reg [15:0] stab_cnt;
  reg halt_d;
  reg done_pulse;
  reg sat_pulse;
  reg [9:0] next_result;

  wire wr_csr;
  wire wr_status;
  wire wr_mask;
  wire rd_high;
  wire active;
  wire restart;
  wire adc_tick;
  wire [9:0] bit_mask;
  wire [9:0] decided;
  wire last_bit;
  wire finish;
  wire settling;
  wire done_clear;
  wire any_sat;
  wire samp_last;
  wire [7:0] csr_view;

  // Release of reset is synchronised; assertion stays asynchronous.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1 <= 1'b0;
      rst_n_int <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n_int <= rst_s1;
    end
  end

  // Analog levels are asynchronous to the core clock.
  // Only the second stage is read, keeping metastability out of the sequencer.
  always @(posedge core_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      comp_s1 <= 1'b0;
      comp_s2 <= 1'b0;
      over_s1 <= 1'b0;
      over_s2 <= 1'b0;
      under_s1 <= 1'b0;
      under_s2 <= 1'b0;
    end else begin
      comp_s1 <= comp_high;
      comp_s2 <= comp_s1;
      over_s1 <= above_upper;
      over_s2 <= over_s1;
      under_s1 <= below_lower;
      under_s2 <= under_s1;
    end
  end

  assign wr_csr = reg_wr & sel(reg_addr, `ADCS_OFF_CSR);
  assign wr_status = reg_wr & sel(reg_addr, `ADCS_OFF_IRQ_STATUS);
  assign wr_mask = reg_wr & sel(reg_addr, `ADCS_OFF_IRQ_MASK);
  assign rd_high = reg_rd & sel(reg_addr, `ADCS_OFF_RES_HIGH);

  // Wait mode has no input here: only halt or the on bit stop work.
  assign active = conv_on & ~halt_mode;
  assign conv_power = active;
  assign mux_channel = channel_field;

  // A channel change while running throws away the conversion in hand.
  // Writing the channel already in use only clears the done flag.
  assign restart = active & wr_csr & (conv_on & reg_wdata[`ADCS_CSR_ON]) &
    (reg_wdata[`ADCS_CSR_CH_HI:`ADCS_CSR_CH_LO] != channel_field);

  // Converter clock enable: every 2nd or every 4th core cycle.
  // A speed change in mid-conversion takes effect from the next tick.
  assign adc_tick = speed ? div_cnt[0] : (div_cnt == 2'b11);

  // The first cycle out of halt still blocks the idle exit while the count loads.
  assign settling = halt_d | (stab_cnt != 16'h0000);

  assign bit_mask = `ADCS_RES_MSB >> bit_idx_shift(bit_idx);
  assign decided = comp_s2 ? trial_code : (trial_code & ~bit_mask);
  assign last_bit = (bit_idx == 4'd0);
  assign finish = active & ~restart & (state == ST_CMP) & adc_tick & last_bit;

  // Either clear path drops the flag; a completion in the same cycle still wins.
  assign done_clear = wr_csr | rd_high;
  assign any_sat = over_s2 | under_s2;
  assign samp_last = (samp_cnt == SAMPLE_TICKS[7:0] - 8'h01);

  // Trial bits count down from the MSB, so the shift is nine minus the index.
  function [3:0] bit_idx_shift;
    input [3:0] idx;
    begin
      bit_idx_shift = 4'd9 - idx;
    end
  endfunction

  // Saturation overrides the approximation at both ends of the range.
  always @* begin
    if (over_s2) begin
      next_result = `ADCS_RES_FULL;
    end else if (under_s2) begin
      next_result = `ADCS_RES_ZERO;
    end else begin
      next_result = decided;
    end
  end

  // Control register; the done flag is not software writable.
  // Channel, speed and on bit all take effect at the write edge.
  always @(posedge core_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      conv_on <= 1'b0;
      speed <= 1'b0;
      channel_field <= 4'h0;
      irq_mask <= 2'b00;
    end else begin
      if (wr_csr) begin
        conv_on <= reg_wdata[`ADCS_CSR_ON];
        speed <= reg_wdata[`ADCS_CSR_SPEED];
        channel_field <= reg_wdata[`ADCS_CSR_CH_HI:`ADCS_CSR_CH_LO];
      end
      if (wr_mask) begin
        irq_mask <= reg_wdata[1:0];
      end
    end
  end

  // Settle counter after leaving halt; conversions wait for it.
  // The count loads on the first cycle out of halt and runs down to zero.
  always @(posedge core_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      halt_d <= 1'b0;
      stab_cnt <= 16'h0000;
    end else begin
      halt_d <= halt_mode;
      if (halt_d & ~halt_mode) begin
        stab_cnt <= STAB_CYC[15:0];
      end else if (stab_cnt != 16'h0000) begin
        stab_cnt <= stab_cnt - 16'h0001;
      end
    end
  end

  // Conversion sequencer: sample, then one set and one decide per bit.
  // The divider runs free from the idle exit, so a decide falls two ticks, at least four
  // core cycles, after its trial code and the comparator synchroniser has caught up.
  // A conversion lasts SAMPLE_TICKS plus twenty converter clock periods.
  always @(posedge core_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      state <= ST_IDLE;
      div_cnt <= 2'b00;
      bit_idx <= 4'd9;
      samp_cnt <= 8'h00;
      trial_code <= 10'h000;
      sample_hold <= 1'b0;
    end else if (!active) begin
      state <= ST_IDLE;
      div_cnt <= 2'b00;
      samp_cnt <= 8'h00;
      trial_code <= 10'h000;
      sample_hold <= 1'b0;
    end else if (restart) begin
      state <= ST_SAMP;
      div_cnt <= 2'b00;
      samp_cnt <= 8'h00;
      trial_code <= 10'h000;
      sample_hold <= 1'b1;
    end else begin
      div_cnt <= (state == ST_IDLE) ? 2'b00 : div_cnt + 2'b01;
      case (state)
        ST_IDLE: begin
          if (!settling) begin
            state <= ST_SAMP;
            sample_hold <= 1'b1;
            samp_cnt <= 8'h00;
          end
        end
        ST_SAMP: begin
          if (adc_tick) begin
            if (samp_last) begin
              state <= ST_SET;
              sample_hold <= 1'b0;
              bit_idx <= 4'd9;
              trial_code <= `ADCS_RES_MSB;
            end else begin
              samp_cnt <= samp_cnt + 8'h01;
            end
          end
        end
        ST_SET: begin
          if (adc_tick) begin
            state <= ST_CMP;
          end
        end
        ST_CMP: begin
          if (adc_tick) begin
            if (last_bit) begin
              state <= ST_SAMP;
              sample_hold <= 1'b1;
              samp_cnt <= 8'h00;
              trial_code <= 10'h000;
            end else begin
              state <= ST_SET;
              bit_idx <= bit_idx - 4'd1;
              trial_code <= decided | (bit_mask >> 1);
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Result and done flag; a completion beats a clear in the same cycle.
  // Both bytes come from one register, so a read pair that straddles a
  // completion mixes two conversions; software must finish the pair in time.
  always @(posedge core_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      result <= `ADCS_RST_RESULT;
      conv_done_flag <= 1'b0;
      done_pulse <= 1'b0;
      sat_pulse <= 1'b0;
    end else begin
      done_pulse <= finish;
      sat_pulse <= finish & any_sat;
      if (finish) begin
        result <= next_result;
        conv_done_flag <= 1'b1;
      end else if (done_clear) begin
        conv_done_flag <= 1'b0;
      end
    end
  end

  // Sticky interrupt events, cleared by writing one; set wins.
  always @(posedge core_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      irq_status <= 2'b00;
    end else begin
      irq_status[`ADCS_IRQ_DONE] <= done_pulse |
        (irq_status[`ADCS_IRQ_DONE] & ~(wr_status & reg_wdata[`ADCS_IRQ_DONE]));
      irq_status[`ADCS_IRQ_SAT] <= sat_pulse |
        (irq_status[`ADCS_IRQ_SAT] & ~(wr_status & reg_wdata[`ADCS_IRQ_SAT]));
    end
  end

  // The line stays high while any unmasked event bit is set.
  assign irq = |(irq_status & irq_mask);

  // Reserved bit four always reads zero, whatever software wrote there.
  assign csr_view = {conv_done_flag, speed, conv_on, 1'b0, channel_field};

  // Read data stand for exactly the cycle after the strobe.
  // Idle cycles return zero, so a late sample never sees stale data.
  always @(posedge core_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      reg_rdata <= `ADCS_RST_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADCS_OFF_CSR: begin
          reg_rdata <= csr_view;
        end
        `ADCS_OFF_RES_HIGH: begin
          reg_rdata <= result[9:2];
        end
        `ADCS_OFF_RES_LOW: begin
          reg_rdata <= {6'b000000, result[1:0]};
        end
        `ADCS_OFF_IRQ_STATUS: begin
          reg_rdata <= {6'b000000, irq_status};
        end
        `ADCS_OFF_IRQ_MASK: begin
          reg_rdata <= {6'b000000, irq_mask};
        end
        default: begin
          reg_rdata <= 8'h00;
        end
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // adcs_control
`default_nettype wire

// >>> sim/adcs_analog_model.sv
/* Analog core model: per-input levels, comparator and range flags.
   Assumes the control block changes trial_code on rising core_clk. */
`timescale 1ns/10ps
`default_nettype none
module adcs_analog_model (
  input wire logic core_clk, // Core clock.
  input wire logic conv_power, // Core power.
  input wire logic [3:0] mux_channel, // Selected input.
  input wire logic [9:0] trial_code, // Trial code.
  output logic comp_high, // Comparator result.
  output logic above_upper, // Input above range.
  output logic below_lower // Input below range.
);
  int lvl [16]; // Level per input: below 0 is under range, above 1023 over it.
  logic comp_q = 1'b0;
  logic over_q = 1'b0;
  logic under_q = 1'b0;
  assign comp_high = comp_q;
  assign above_upper = over_q;
  assign below_lower = under_q;
  always @(posedge core_clk) begin
    if (conv_power) begin
      comp_q <= lvl[mux_channel] >= int'(trial_code);
      over_q <= lvl[mux_channel] > 1023;
      under_q <= lvl[mux_channel] < 0;
    end else begin
      // An unpowered core holds nothing, so its outputs wander.
      comp_q <= ~comp_q;
      over_q <= ~over_q;
      under_q <= ~under_q;
    end
  end
endmodule // adcs_analog_model
`default_nettype wire

// >>> sim/adcs_control_assertions.sv
/* Port checker for the converter control block.
   Assumes the bus master keeps one-cycle strobes. */
`timescale 1ns/10ps
`default_nettype none
module adcs_control_assertions (
  input wire logic core_clk, // Core clock.
  input wire logic reset_n, // Reset, active low.
  input wire logic [7:0] reg_addr, // Address.
  input wire logic [7:0] reg_wdata, // Write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  input wire logic [7:0] reg_rdata, // Read data.
  input wire logic halt_mode, // Halt level.
  input wire logic conv_power, // Core power.
  input wire logic [3:0] mux_channel, // Input select.
  input wire logic sample_hold, // Sample phase.
  input wire logic [9:0] trial_code, // Trial code.
  input wire logic irq // Interrupt.
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire csr_wr = reg_wr && reg_addr == 8'h70;
  power_follow_a: assert property (csr_wr |=>
    conv_power == ($past(reg_wdata[5]) && !halt_mode)) else $error("power mismatch");
  halt_off_a: assert property (halt_mode |-> !conv_power)
    else $error("powered in halt");
  chan_sel_a: assert property (csr_wr |=> mux_channel == $past(reg_wdata[3:0]))
    else $error("channel mismatch");
  chan_restart_a: assert property (csr_wr && conv_power && reg_wdata[5] && !halt_mode
    && reg_wdata[3:0] != mux_channel |-> ##[1:3] sample_hold) else $error("no restart");
  idle_off_a: assert property (!conv_power [*2] |->
    trial_code == 10'h000 && !sample_hold) else $error("active while off");
  low_zero_a: assert property (reg_rd && reg_addr == 8'h72 |=>
    reg_rdata[7:2] == 6'h00) else $error("low byte upper bits set");
  rsvd_zero_a: assert property (reg_rd && reg_addr == 8'h70 |=> !reg_rdata[4])
    else $error("reserved bit set");
  csr_back_a: assert property (csr_wr ##2 (reg_rd && reg_addr == 8'h70) |=>
    reg_rdata[6:0] == {$past(reg_wdata[6:5], 3), 1'b0, $past(reg_wdata[3:0], 3)})
    else $error("control readback mismatch");
  cover property (csr_wr && reg_wdata[5]);
  cover property (halt_mode && mux_channel == 4'h3);
  cover property ($rose(irq));
endmodule // adcs_control_assertions
bind adcs_control adcs_control_assertions chk (.core_clk(core_clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .halt_mode(halt_mode), .conv_power(conv_power),
  .mux_channel(mux_channel), .sample_hold(sample_hold), .trial_code(trial_code), .irq(irq));
`default_nettype wire

// >>> sim/tb_top.sv
/* Self-checking bench for the converter control block.
   Assumes the analog model answers on the same clock. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic halt_mode = 1'b0;
  wire [7:0] reg_rdata;
  wire comp_high, above_upper, below_lower, conv_power, sample_hold, irq;
  wire [3:0] mux_channel;
  wire [9:0] trial_code;
  int failures = 0;
  int checks_done = 0;
  int nf, ns, n;
  logic [7:0] v;
  always #4 core_clk = ~core_clk;
  adcs_control #(.SAMPLE_TICKS(1), .STAB_CYC(4)) uut (.core_clk(core_clk),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_mode(halt_mode), .comp_high(comp_high),
    .above_upper(above_upper), .below_lower(below_lower), .conv_power(conv_power),
    .mux_channel(mux_channel), .sample_hold(sample_hold), .trial_code(trial_code), .irq(irq));
  adcs_analog_model pm (.core_clk(core_clk), .conv_power(conv_power),
    .mux_channel(mux_channel), .trial_code(trial_code), .comp_high(comp_high),
    .above_upper(above_upper), .below_lower(below_lower));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (failures == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Every access leaves one idle cycle, so no strobe is assigned twice at one edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask
  task automatic wait_done(output int cnt);
    logic [7:0] s;
    cnt = 0;
    do begin
      rd(8'h70, s);
      cnt++;
    end while (s[7] !== 1'b1 && cnt < 300);
    check(s[7], 1'b1);
  endtask
  task automatic t_conv(input logic [3:0] ch, input int lv, input logic sp,
                        input logic [9:0] exp, output int cnt);
    logic [7:0] lo, hi;
    pm.lvl[ch] = lv;
    wr(8'h70, {1'b0, sp, 1'b1, 1'b0, ch});
    wait_done(cnt);
    rd(8'h72, lo);
    rd(8'h71, hi);
    check({hi, lo[1:0]}, exp);
    check(lo[7:2], 6'h00);
    rd(8'h70, lo);
    check(lo[7], 1'b0);
  endtask
  task automatic t_regs;
    rd(8'h70, v);
    check(v, 8'h00);
    rd(8'h71, v);
    check(v, 8'h00);
    rd(8'h72, v);
    check(v, 8'h00);
    wr(8'h70, 8'hEF);
    rd(8'h70, v);
    check(v, 8'h6F);
    wr(8'h70, 8'h00);
    check(conv_power, 1'b0);
  endtask
  task automatic t_irq;
    wr(8'h74, 8'h00);
    wr(8'h70, 8'h23);
    wait_done(n);
    check(irq, 1'b0);
    wr(8'h74, 8'h01);
    check(irq, 1'b1);
    wr(8'h70, 8'h00);
    wr(8'h73, 8'h03);
    check(irq, 1'b0);
  endtask
  task automatic t_halt;
    wr(8'h70, 8'h23);
    halt_mode <= 1'b1;
    repeat (20) @(posedge core_clk);
    check(conv_power, 1'b0);
    halt_mode <= 1'b0;
    repeat (3) @(posedge core_clk);
    check(conv_power, 1'b1);
    check(sample_hold, 1'b0);
    wait_done(n);
    rd(8'h71, v);
    check(v, 8'hA9);
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_regs();
    t_conv(4'h3, 677, 1'b1, 10'h2A5, nf);
    rd(8'h73, v);
    check(v[1], 1'b0);
    t_conv(4'hF, 1024, 1'b1, 10'h3FF, n);
    rd(8'h73, v);
    check(v[1], 1'b1);
    wr(8'h73, 8'h02);
    t_conv(4'h0, -1, 1'b1, 10'h000, n);
    rd(8'h73, v);
    check(v[1], 1'b1);
    t_conv(4'h9, 341, 1'b0, 10'h155, ns);
    check(ns > nf, 1'b1);
    wait_done(n);
    t_conv(4'h3, 677, 1'b1, 10'h2A5, n);
    t_irq();
    t_halt();
    wrap_up();
  end
  initial begin
    #400000;
    failures++;
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
